// ==== uart_baud_rate_control.v ====
/*
  Serial port mode control, flag handling and bit rate generation.
  Assumes a frame engine on the same clock that reports frame events
  as one-cycle pulses, a Timer 1 overflow pulse on the same clock,
  and a register master that never issues read and write together.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_regs.vh"

// Function
// - Shift mode bit rate is clock/6
// - Mode 2 rate clock/32, or /16 doubled
// - Source select picks generator or Timer 1
// - Doubler bypasses divide-by-2 on mode 2, Timer 1 and generator clocking
// - 12-bit up counter reloads after FFF
// - Reload low byte and high nibble
// - Writing high reload forces counter reload
// - Generator rate formula with 4096 minus reload
// - Timer 1 rate is overflow rate scaled
// - Two mode bits decode four modes
// - Nine-bit filter drops ninth bit zero
// - Eight-bit filter needs valid stop bit
// - Reception only while receive enable set
// - Transmit ninth bit from software field
// - Receive ninth field holds ninth/stop bit
// - Transmit flag set by hardware, software clears
// - Receive flag set by hardware, software clears
// - Source select clear after reset
// - Sample clock is sixteen times bit rate outside shift mode, equal to it in shift mode
module uart_baud_rate_control #(
  parameter RW = 12
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rd_data_o,
  // Timer 1 overflow pulse
  input wire timer1_ovf_i,
  // Frame engine events
  input wire tx_stop_start_i,
  input wire rx_frame_done_i,
  input wire rx_ninth_i,
  input wire rx_stop_i,
  input wire bit_sync_i,
  // Control toward the frame engine
  output reg [1:0] mode_o,
  output reg rx_enable_o,
  output reg tx_ninth_bit_o,
  output reg tx_done_flag_o,
  output reg rx_done_flag_o,
  output reg rx_load_o,
  // Rate ticks
  output reg sample_tick_o,
  output reg bit_tick_o
);

  // Serial mode control fields
  reg [1:0] mode_reg;
  reg multiproc_filter_reg;
  reg rx_en_reg;
  reg tx_ninth_bit_reg;
  reg rx_ninth_bit_reg;
  reg tx_done_flag_reg;
  reg rx_done_flag_reg;

  // Rate control fields
  reg [7:0] reload_lo_reg;
  reg [3:0] reload_hi_reg;
  reg rate_source_select_reg;
  reg rate_doubler_reg;

  // Rate path state
  reg half_reg;
  reg [2:0] shift_div_reg;
  reg [3:0] ovs_cnt_reg;
  reg force_reload_reg;

  // Next values
  reg tx_done_flag_next;
  reg rx_done_flag_next;
  reg rx_ninth_bit_next;
  reg [7:0] rd_data_next;

  // Decoded writes
  wire wr_smc = wr_i && (addr_i == `SMC_ADDR);
  wire wr_rlo = wr_i && (addr_i == `RLD_LO_ADDR);
  wire wr_rhi = wr_i && (addr_i == `RLD_HI_ADDR);
  wire wr_pwr = wr_i && (addr_i == `PWR_ADDR);

  // Mode decode
  wire is_shift = (mode_reg == `MODE_SHIFT);
  wire is_uart8 = (mode_reg == `MODE_UART8);
  wire is_fixed9 = (mode_reg == `MODE_UART9F);
  wire is_var = mode_reg[0];
  wire is_nine = mode_reg[1];

  // Generator instance
  wire gen_ovf;
  wire [RW-1:0] gen_count;
  wire [RW-1:0] gen_reload = {reload_hi_reg, reload_lo_reg};

  rate_gen12 #(
    .W(RW)
  ) u_gen (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .reload_i(gen_reload),
    .force_i(force_reload_reg),
    .ovf_o(gen_ovf),
    .count_o(gen_count)
  );

  // Source of the pre-divider tick per mode
  wire var_src = rate_source_select_reg ? gen_ovf : timer1_ovf_i;
  wire src_tick = is_fixed9 ? 1'b1 : (is_var & var_src);

  // Divide-by-2 stage, bypassed when doubled
  wire pass_tick = rate_doubler_reg ? src_tick : (src_tick && half_reg);

  // Shift mode divider
  wire shift_tick = (shift_div_reg == (`SHIFT_DIV - 3'h1));

  // Receive filter: nine-bit needs ninth set, eight-bit a stop bit
  reg filter_ok;
  always @* begin
    filter_ok = 1'b1;
    if (multiproc_filter_reg) begin
      if (is_nine) begin
        filter_ok = rx_ninth_i;
      end else if (is_uart8) begin
        filter_ok = rx_stop_i;
      end
    end
  end

  // Frame is kept only if enabled, flag free and filter passes
  wire rx_accept = rx_frame_done_i && rx_en_reg && !rx_done_flag_reg
    && filter_ok;

  // Flag and ninth bit next values; hardware set beats software clear
  always @* begin
    tx_done_flag_next = tx_done_flag_reg;
    rx_done_flag_next = rx_done_flag_reg;
    rx_ninth_bit_next = rx_ninth_bit_reg;
    if (wr_smc) begin
      tx_done_flag_next = wr_data_i[`SMC_TI];
      rx_done_flag_next = wr_data_i[`SMC_RI];
      rx_ninth_bit_next = wr_data_i[`SMC_RB8];
    end
    if (tx_stop_start_i) begin
      tx_done_flag_next = 1'b1;
    end
    if (rx_accept) begin
      rx_done_flag_next = 1'b1;
      if (is_nine) begin
        rx_ninth_bit_next = rx_ninth_i;
      end else if (is_uart8) begin
        rx_ninth_bit_next = rx_stop_i;
      end
    end
  end

  // Read multiplexer; unmapped and reserved bits read zero
  always @* begin
    rd_data_next = 8'h00;
    case (addr_i)
      `SMC_ADDR: begin
        rd_data_next = {mode_reg, multiproc_filter_reg, rx_en_reg,
          tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg,
          rx_done_flag_reg};
      end
      `RLD_LO_ADDR: begin
        rd_data_next = reload_lo_reg;
      end
      `RLD_HI_ADDR: begin
        rd_data_next = {rate_source_select_reg, 3'h0, reload_hi_reg};
      end
      `PWR_ADDR: begin
        rd_data_next = {rate_doubler_reg, 7'h00};
      end
      `CNT_LO_ADDR: begin
        rd_data_next = gen_count[7:0];
      end
      `CNT_HI_ADDR: begin
        rd_data_next = {4'h0, gen_count[RW-1:8]};
      end
      `STAT_ADDR: begin
        rd_data_next = {ovs_cnt_reg, 2'h0, half_reg, var_src};
      end
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // Software writable fields
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_reg <= 2'h0;
      multiproc_filter_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_ninth_bit_reg <= 1'b0;
      reload_lo_reg <= `RLD_LO_RST;
      reload_hi_reg <= 4'h0;
      rate_source_select_reg <= 1'b0;
      rate_doubler_reg <= 1'b0;
      force_reload_reg <= 1'b0;
    end else if (ce_i) begin
      // Reload fires the cycle after the write so the new nibble is used
      force_reload_reg <= wr_rhi;
      if (wr_smc) begin
        mode_reg <= {wr_data_i[`SMC_MODE_HI], wr_data_i[`SMC_MODE_LO]};
        multiproc_filter_reg <= wr_data_i[`SMC_MPF];
        rx_en_reg <= wr_data_i[`SMC_REN];
        tx_ninth_bit_reg <= wr_data_i[`SMC_TB8];
      end
      if (wr_rlo) begin
        reload_lo_reg <= wr_data_i;
      end
      if (wr_rhi) begin
        reload_hi_reg <= wr_data_i[3:0];
        rate_source_select_reg <= wr_data_i[`RLD_HI_SRC];
      end
      if (wr_pwr) begin
        rate_doubler_reg <= wr_data_i[`PWR_DBL];
      end
    end
  end

  // Hardware-set flags and captured ninth bit
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_done_flag_reg <= 1'b0;
      rx_done_flag_reg <= 1'b0;
      rx_ninth_bit_reg <= 1'b0;
    end else if (ce_i) begin
      tx_done_flag_reg <= tx_done_flag_next;
      rx_done_flag_reg <= rx_done_flag_next;
      rx_ninth_bit_reg <= rx_ninth_bit_next;
    end
  end

  // Rate dividers: halver, shift mode by six, sixteen-fold sampler
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      half_reg <= 1'b0;
      shift_div_reg <= 3'h0;
      ovs_cnt_reg <= 4'h0;
    end else if (ce_i) begin
      if (src_tick && !rate_doubler_reg) begin
        half_reg <= !half_reg;
      end
      // Shift mode ignores the doubler and both sources
      if (!is_shift || shift_tick) begin
        shift_div_reg <= 3'h0;
      end else begin
        shift_div_reg <= shift_div_reg + 3'h1;
      end
      // Start edge realigns bit boundaries to the incoming frame
      if (bit_sync_i) begin
        ovs_cnt_reg <= 4'h0;
      end else if (!is_shift && pass_tick) begin
        ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
      end
    end
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_o <= 2'b00;
      rx_enable_o <= 1'b0;
      tx_ninth_bit_o <= 1'b0;
      tx_done_flag_o <= 1'b0;
      rx_done_flag_o <= 1'b0;
      rx_load_o <= 1'b0;
      sample_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else if (ce_i) begin
      mode_o <= mode_reg;
      rx_enable_o <= rx_en_reg;
      tx_ninth_bit_o <= tx_ninth_bit_reg && is_nine;
      tx_done_flag_o <= tx_done_flag_next;
      rx_done_flag_o <= rx_done_flag_next;
      // Lost frames give no load pulse at all
      rx_load_o <= rx_accept;
      if (is_shift) begin
        sample_tick_o <= shift_tick;
        bit_tick_o <= shift_tick;
      end else begin
        sample_tick_o <= pass_tick && !bit_sync_i;
        bit_tick_o <= pass_tick && !bit_sync_i
          && (ovs_cnt_reg == `OVS_LAST);
      end
      rd_data_o <= rd_i ? rd_data_next : 8'h00;
    end
  end

endmodule

`default_nettype wire

// ==== uart_baud_regs.vh ====
/*
  Register offsets, field positions, reset values and divider counts
  for the serial port rate and mode control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef UART_BAUD_REGS_VH
`define UART_BAUD_REGS_VH

// Register offsets on the plain register port
`define SMC_ADDR 8'h00
`define RLD_LO_ADDR 8'h01
`define RLD_HI_ADDR 8'h02
`define PWR_ADDR 8'h03
`define CNT_LO_ADDR 8'h04
`define CNT_HI_ADDR 8'h05
`define STAT_ADDR 8'h06

// Field positions in serial_mode_control
`define SMC_MODE_HI 7
`define SMC_MODE_LO 6
`define SMC_MPF 5
`define SMC_REN 4
`define SMC_TB8 3
`define SMC_RB8 2
`define SMC_TI 1
`define SMC_RI 0

// Field positions in the high reload and power registers
`define RLD_HI_SRC 7
`define PWR_DBL 7

// Reset values
`define SMC_RST 8'h00
`define RLD_LO_RST 8'h00
`define RLD_HI_RST 8'h00
`define PWR_RST 8'h00

// Mode encodings
`define MODE_SHIFT 2'b00
`define MODE_UART8 2'b01
`define MODE_UART9F 2'b10
`define MODE_UART9V 2'b11

// Divider counts
`define SHIFT_DIV 3'h6
`define OVS_LAST 4'hf

`endif

// ==== rate_gen12.v ====
/*
  Free running auto-reload rate counter with overflow pulse.
  Assumes one clock, synchronous active high reset, and a clock
  enable that freezes the count.
*/
`timescale 1ns/1ps
`default_nettype none

module rate_gen12 #(
  parameter W = 12
) (
  // Clock and control
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // Reload interface
  input wire [W-1:0] reload_i,
  input wire force_i,
  // Outputs
  output reg ovf_o,
  output reg [W-1:0] count_o
);

  // Count up, reload on the step after all ones
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_o <= {W{1'b0}};
      ovf_o <= 1'b0;
    end else if (ce_i) begin
      ovf_o <= 1'b0;
      if (force_i) begin
        count_o <= reload_i;
      end else if (&count_o) begin
        count_o <= reload_i;
        ovf_o <= 1'b1;
      end else begin
        count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ==== uart_baud_rate_control_props.sv ====
/* Checker for the serial rate and mode control block.
   Assumes one clock; attempts spanning a frozen enable are skipped. */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_rate_control_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Inputs watched
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic tx_stop_start_i,
  input wire logic rx_frame_done_i,
  input wire logic rx_ninth_i,
  input wire logic rx_stop_i,
  // Outputs watched
  input wire logic [1:0] mode_o,
  input wire logic rx_enable_o,
  input wire logic tx_ninth_bit_o,
  input wire logic tx_done_flag_o,
  input wire logic rx_done_flag_o,
  input wire logic rx_load_o,
  input wire logic bit_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);
  // Control register write
  wire logic smc_wr = wr_i && addr_i == 8'h00;
  // Field lands one edge after the write, the output copy one edge later
  property p_mode; smc_wr |-> ##2 mode_o == $past(wr_data_i[7:6], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode bits not taken");
  property p_ren; smc_wr |-> ##2 rx_enable_o == $past(wr_data_i[4], 2); endproperty
  a_ren: assert property (p_ren) else $error("receive enable not taken");
  property p_tx9;
    smc_wr |-> ##2 tx_ninth_bit_o == ($past(wr_data_i[7], 2) & $past(wr_data_i[3], 2));
  endproperty
  a_tx9: assert property (p_tx9) else $error("tx ninth bit wrong");
  property p_txf; tx_stop_start_i |=> tx_done_flag_o; endproperty
  a_txf: assert property (p_txf) else $error("tx flag not set");
  property p_txhold; tx_done_flag_o && !smc_wr |=> tx_done_flag_o; endproperty
  a_txhold: assert property (p_txhold) else $error("tx flag dropped");
  property p_rxset;
    rx_frame_done_i && rx_enable_o && !rx_done_flag_o &&
    (mode_o == 2'b00 || (mode_o[1] ? rx_ninth_i : rx_stop_i)) |=> rx_done_flag_o && rx_load_o;
  endproperty
  a_rxset: assert property (p_rxset) else $error("frame not accepted");
  property p_rxoff; rx_frame_done_i && !rx_enable_o |=> !rx_load_o; endproperty
  a_rxoff: assert property (p_rxoff) else $error("load while disabled");
  // Only judged once mode 0 has settled
  property p_shift;
    (mode_o == 2'b00)[*7] ##0 bit_tick_o ##1 (mode_o == 2'b00)[*6] |-> bit_tick_o;
  endproperty
  a_shift: assert property (p_shift) else $error("shift rate not six");
endmodule
bind uart_baud_rate_control uart_baud_rate_control_chk u_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .tx_stop_start_i(tx_stop_start_i), .rx_frame_done_i(rx_frame_done_i),
  .rx_ninth_i(rx_ninth_i), .rx_stop_i(rx_stop_i), .mode_o(mode_o),
  .rx_enable_o(rx_enable_o), .tx_ninth_bit_o(tx_ninth_bit_o),
  .tx_done_flag_o(tx_done_flag_o), .rx_done_flag_o(rx_done_flag_o),
  .rx_load_o(rx_load_o), .bit_tick_o(bit_tick_o));
`default_nettype wire

// ==== serial_node_model.sv ====
/* Frame engine and Timer 1 stand-in on the far side.
   Assumes the bench pulses each request for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module serial_node_model #(
  parameter int T1_DIV = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Requests from the bench
  input wire logic rx_req_i,
  input wire logic tx_req_i,
  input wire logic ninth_i,
  input wire logic stop_i,
  // Toward the block
  output logic timer1_ovf_o,
  output logic bit_sync_o,
  output logic rx_frame_done_o,
  output logic rx_ninth_o,
  output logic rx_stop_o,
  output logic tx_stop_start_o
);
  int t1_cnt;
  logic [1:0] rx_pipe;
  logic n_hold;
  logic s_hold;
  // Timer 1 in auto-reload, frame events one pulse each
  always @(posedge clk_i) begin
    if (sys_rst_i || t1_cnt == T1_DIV - 1)
      t1_cnt <= 0;
    else
      t1_cnt <= t1_cnt + 1;
    timer1_ovf_o <= !sys_rst_i && t1_cnt == T1_DIV - 1;
    rx_pipe <= sys_rst_i ? 2'b00 : {rx_pipe[0], rx_req_i};
    tx_stop_start_o <= tx_req_i && !sys_rst_i;
    if (sys_rst_i || rx_req_i) begin
      n_hold <= ninth_i && !sys_rst_i;
      s_hold <= stop_i && !sys_rst_i;
    end
  end
  // Start edge first, then the final shift
  assign bit_sync_o = rx_pipe[0];
  assign rx_frame_done_o = rx_pipe[1];
  // Bit lines are stale outside the pulse, so show the inverse
  assign rx_ninth_o = rx_frame_done_o ? n_hold : !n_hold;
  assign rx_stop_o = rx_frame_done_o ? s_hold : !s_hold;
endmodule
`default_nettype wire

// ==== uart_baud_rate_control_bench.sv ====
/* Self-checking bench: rates, control register and frame flags.
   Assumes the checker is bound; ce_i is dropped once at the end. */
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL %0t got %h want %h", $time, a, b); end end
module uart_baud_rate_control_bench;
  localparam int T1_DIV = 5;
  logic clk_i = 0;
  logic rst = 1;
  logic ce = 1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr = 0, rd = 0, rx_req = 0, tx_req = 0, nin = 0, stp = 0;
  logic [7:0] rdat;
  logic [1:0] mode;
  logic ren, tx9, txf, rxf, rxl, stick, btick, t1, bsync, rxd, rx9, rxs, txs;
  int seed = 92386;
  int bad_count = 0;
  int checked = 0;
  always #10 clk_i = ~clk_i;
  uart_baud_rate_control u_uart_baud_rate_control (.clk_i(clk_i), .sys_rst_i(rst),
    .ce_i(ce), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
    .timer1_ovf_i(t1), .tx_stop_start_i(txs), .rx_frame_done_i(rxd), .rx_ninth_i(rx9),
    .rx_stop_i(rxs), .bit_sync_i(bsync), .mode_o(mode), .rx_enable_o(ren),
    .tx_ninth_bit_o(tx9), .tx_done_flag_o(txf), .rx_done_flag_o(rxf), .rx_load_o(rxl),
    .sample_tick_o(stick), .bit_tick_o(btick));
  serial_node_model #(.T1_DIV(T1_DIV)) u_serial_node_model (.clk_i(clk_i), .sys_rst_i(rst),
    .rx_req_i(rx_req), .tx_req_i(tx_req), .ninth_i(nin), .stop_i(stp), .timer1_ovf_o(t1),
    .bit_sync_o(bsync), .rx_frame_done_o(rxd), .rx_ninth_o(rx9), .rx_stop_o(rxs),
    .tx_stop_start_o(txs));
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // First interval after a change may be short, so time the second
  task automatic rate(input logic [7:0] pw, hi, smc, input int want);
    int n;
    wreg(8'h03, pw);
    wreg(8'h02, hi);
    wreg(8'h00, smc);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      #1 n = 1;
      while (btick !== 1'b1 && n < 9000) begin
        @(posedge clk_i);
        #1 n++;
      end
    end
    `chk(n, want)
    // Sample clock runs sixteen times the bit rate outside shift mode
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      #1 n = 1;
      while (stick !== 1'b1 && n < 9000) begin
        @(posedge clk_i);
        #1 n++;
      end
    end
    `chk(n, (smc[7:6] == 2'b00) ? want : want / 16)
  endtask
  task automatic close_out;
    $display("Counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [7:0] d;
    logic [11:0] r;
    logic [1:0] m;
    logic f, en, t, n, s, x, e9, acc;
    r = {8'hff, 4'($random(seed))};
    repeat (2) @(posedge clk_i);
    rst <= 1'b0;
    // Reset values, plus an unmapped hole
    for (int a = 0; a < 8; a++) begin
      if (a < 4 || a == 7) begin
        rreg(8'(a), d);
        `chk(d, 8'h00)
      end
    end
    rate(8'h00, 8'h00, 8'h00, 6);
    rate(8'h00, 8'h00, 8'h80, 32);
    rate(8'h80, 8'h00, 8'h80, 16);
    rate(8'h00, 8'h00, 8'h40, 32 * T1_DIV);
    rate(8'h80, 8'h00, 8'hc0, 16 * T1_DIV);
    wreg(8'h01, r[7:0]);
    rate(8'h80, {4'h8, r[11:8]}, 8'hc0, 16 * (4096 - r));
    // Live count never drops below the reload, so its top nibble is fixed
    rreg(8'h05, d);
    `chk(d, {4'h0, r[11:8]})
    rate(8'h00, {4'h8, r[11:8]}, 8'h40, 32 * (4096 - r));
    // Random frames over all modes, filter and enable settings
    e9 = 1'b0;
    repeat (40) begin
      m = 2'($random(seed));
      f = (m != 2'b00) && 1'($random(seed));
      en = 1'($random(seed));
      t = 1'($random(seed));
      n = 1'($random(seed));
      s = 1'($random(seed));
      x = 1'($random(seed));
      wreg(8'h00, {m, f, en, t, e9, 2'b00});
      @(posedge clk_i);
      nin <= n;
      stp <= s;
      rx_req <= 1'b1;
      tx_req <= x;
      @(posedge clk_i);
      rx_req <= 1'b0;
      tx_req <= 1'b0;
      repeat (4) @(posedge clk_i);
      acc = en && (m == 2'b00 || !f || (m[1] ? n : s));
      if (acc && m != 2'b00)
        e9 = m[1] ? n : s;
      rreg(8'h00, d);
      `chk(d, {m, f, en, t, e9, x, acc})
      `chk(tx9, t & m[1])
    end
    // Frozen clock enable ignores a write
    ce <= 1'b0;
    wreg(8'h01, ~r[7:0]);
    ce <= 1'b1;
    rreg(8'h01, d);
    `chk(d, r[7:0])
    close_out;
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
